/* shared/mie_pkg.sv */
// Shared constants and types for the instruction execution core
package mie_pkg;
	localparam int IW = 16;
	localparam int PC_W = 11;
	localparam int DW = 8;
	// Register bus byte offsets
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_STATUS = 5'h04;
	localparam logic [4:0] REG_PC = 5'h08;
	localparam logic [4:0] REG_ACC = 5'h0C;
	localparam logic [4:0] REG_WDT = 5'h10;
	localparam int CTRL_RUN = 0;
	localparam int CTRL_WAKE = 1;
	localparam int CTRL_IRQ_OFF = 2;
	localparam logic CTRL_RUN_RST = 1'b0;
	// Data addresses of the special registers
	localparam logic [7:0] PCL_ADDR = 8'h06;
	localparam logic [7:0] TBLP_ADDR = 8'h07;
	localparam logic [7:0] TABLE_HIGH_LATCH_ADDR = 8'h08;
	localparam logic [7:0] TBHP_ADDR = 8'h09;
	localparam logic [2:0] LAST_PAGE = 3'h7;
	localparam logic [3:0] BCD_MAX = 4'h9;
	localparam logic [3:0] BCD_ADJ = 4'h6;
	localparam logic [1:0] PH_LAST = 2'h3;

	typedef enum logic [1:0] {
		PH_FETCH = 2'b00,
		PH_READ = 2'b01,
		PH_EXEC = 2'b10,
		PH_DONE = 2'b11
	} mie_phase_t;

	typedef enum logic [4:0] {
		OP_NOP = 5'h00, OP_MOVAM = 5'h01, OP_MOVMA = 5'h02,
		OP_MOVAX = 5'h03, OP_CLRB = 5'h04, OP_SETB = 5'h05,
		OP_JMP = 5'h06, OP_SZ = 5'h07, OP_SZA = 5'h08,
		OP_SZB = 5'h09, OP_SNZB = 5'h0A, OP_SIZ = 5'h0B,
		OP_SDZ = 5'h0C, OP_SIZA = 5'h0D, OP_SDZA = 5'h0E,
		OP_CALL = 5'h0F, OP_RET = 5'h10, OP_RETA = 5'h11,
		OP_INTERRUPT_RETURN = 5'h12, OP_TABLE_READ_PAGE = 5'h13, OP_TABLE_READ_FINAL_PAGE = 5'h14,
		OP_CLR = 5'h15, OP_SET = 5'h16, OP_KICK = 5'h17,
		OP_HALT = 5'h18, OP_ALUA = 5'h1B, OP_ALUM = 5'h1C,
		OP_ALUX = 5'h1D
	} mie_op_t;

	typedef enum logic [2:0] {
		ALU_ADD = 3'h0, ALU_ADC = 3'h1, ALU_AND = 3'h2,
		ALU_CPL = 3'h3, ALU_DAA = 3'h4, ALU_SWAP = 3'h5
	} mie_alu_op_t;

	typedef struct packed {
		logic [7:0] res;
		logic c;
		logic ac;
		logic ov;
		logic z;
	} mie_alu_res_t;

	typedef struct packed {
		logic global_irq_enable;
		logic to;
		logic sleep_entry_flag;
		logic ov;
		logic z;
		logic ac;
		logic c;
	} mie_flags_t;
endpackage

/* logic/mie_dmem.sv */
// Data memory with registered read port
`timescale 1ns/1ns
module mie_dmem #(
	parameter int DEPTH = 256,
	parameter int AW = 8
) (
	input wire logic sys_clk_in,
	input wire logic we_in,
	input wire logic [AW-1:0] addr_in,
	input wire logic [7:0] wdata_in,
	output logic [7:0] rdata_out
);
	logic [7:0] mem_q [DEPTH];

	always_ff @(posedge sys_clk_in) begin
		if (we_in) begin
			mem_q[addr_in] <= wdata_in;
		end
		rdata_out <= mem_q[addr_in];
	end
endmodule // mie_dmem

/* logic/mie_alu.sv */
// Arithmetic and logic unit of the core
`timescale 1ns/1ns
module mie_alu (
	input wire logic [7:0] acc_in,
	input wire logic [7:0] opnd_in,
	input wire logic carry_in,
	input wire logic nib_in,
	input mie_pkg::mie_alu_op_t op_in,
	output mie_pkg::mie_alu_res_t res_out
);
	import mie_pkg::*;
	logic cin_w;
	logic [8:0] sum_w;
	logic [4:0] lo_w;
	logic lo_adj_w;
	logic hi_adj_w;
	logic [8:0] daa_w;
	logic [7:0] res_w;

	assign cin_w = (op_in == ALU_ADC) & carry_in;
	assign sum_w = {1'b0, acc_in} + {1'b0, opnd_in} + {8'h00, cin_w};
	// half carry out of bit three
	assign lo_w = {1'b0, acc_in[3:0]} + {1'b0, opnd_in[3:0]} + {4'h0, cin_w};
	assign lo_adj_w = (acc_in[3:0] > BCD_MAX) | nib_in;
	assign hi_adj_w = (acc_in[7:4] > BCD_MAX) | carry_in;
	assign daa_w = {1'b0, acc_in} + {1'b0, hi_adj_w ? BCD_ADJ : 4'h0,
		lo_adj_w ? BCD_ADJ : 4'h0};
	assign res_w = (op_in == ALU_AND) ? (acc_in & opnd_in) :
		(op_in == ALU_CPL) ? ~opnd_in :
		(op_in == ALU_DAA) ? daa_w[7:0] :
		(op_in == ALU_SWAP) ? {opnd_in[3:0], opnd_in[7:4]} : sum_w[7:0];
	assign res_out.res = res_w;
	assign res_out.c = (op_in == ALU_DAA) ? (daa_w[8] | carry_in) : sum_w[8];
	assign res_out.ac = lo_w[4];
	assign res_out.ov = (acc_in[7] == opnd_in[7]) & (sum_w[7] != acc_in[7]);
	assign res_out.z = (res_w == 8'h00);
endmodule // mie_alu

/* logic/mie_core.sv */
// Instruction execution core with Avalon-MM control port
//
// Decided for this implementation: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ns
module mie_core #(
	parameter int DMEM_DEPTH = 256,
	parameter int STACK_DEPTH = 4,
	parameter int WDT_BITS = 13
) (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic [4:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	output logic [mie_pkg::PC_W-1:0] prog_addr_out,
	input wire logic [mie_pkg::IW-1:0] prog_data_in,
	output logic halted_out
);
	import mie_pkg::*;
	localparam int SPW = $clog2(STACK_DEPTH);

	// ==========================================
	// State
	// ==========================================
	mie_phase_t ph_q, ph_d;
	logic [PC_W-1:0] pc_q;
	logic [IW-1:0] ir_q;
	logic [IW-1:0] tword_q;
	logic [7:0] acc_q;
	mie_flags_t fl_q;
	logic dummy_q;
	logic tbl_pend_q;
	logic [PC_W-1:0] tbl_addr_q;
	logic [7:0] tblp_q;
	logic [7:0] tbhp_q;
	logic [7:0] table_high_latch_q;
	logic halt_q;
	logic run_en_q;
	logic ack_q;
	logic [WDT_BITS-1:0] wdt_q;
	logic [PC_W-1:0] stack_q [STACK_DEPTH];
	logic [SPW-1:0] sp_q;

	// ==========================================
	// Decode
	// ==========================================
	mie_op_t opc_w;
	mie_alu_op_t alu_op_w;
	mie_alu_res_t alu_w;
	logic run_w, exec_w, dum_w, cyc_end_w;
	logic [7:0] m_w, mask_w, ram_rd_w, mem_w, alu_b_w;
	logic [PC_W-1:0] tgt_w, pop_w;
	logic [7:0] res_w;
	logic wr_mem_w, wr_acc_w, skip_w, jmp_w, call_w, ret_w, interrupt_return_w;
	logic tbl_w, tbl_last_w, kick_w, halt_w, upd_ar_w, upd_z_w, upd_c_w;
	logic pcl_w, ram_we_w, wdt_exp_w, bus_w, bus_wr_w;
	logic [7:0] ram_wd_w;

	assign run_w = run_en_q & ~halt_q;
	assign exec_w = run_w & (ph_q == PH_EXEC) & ~dummy_q;
	assign dum_w = run_w & (ph_q == PH_EXEC) & dummy_q;
	assign cyc_end_w = run_w & (ph_q == PH_DONE);
	assign opc_w = mie_op_t'(ir_q[15:11]);
	assign alu_op_w = mie_alu_op_t'(ir_q[10:8]);
	assign m_w = ir_q[7:0];
	assign tgt_w = ir_q[PC_W-1:0];
	assign mask_w = 8'h01 << ir_q[10:8];
	assign pop_w = stack_q[sp_q - SPW'(1)];
	assign mem_w = (m_w == PCL_ADDR) ? pc_q[7:0] :
		(m_w == TBLP_ADDR) ? tblp_q :
		(m_w == TABLE_HIGH_LATCH_ADDR) ? table_high_latch_q :
		(m_w == TBHP_ADDR) ? tbhp_q : ram_rd_w;
	assign alu_b_w = (opc_w == OP_ALUX) ? m_w : mem_w;
	assign prog_addr_out = tbl_pend_q ? tbl_addr_q : pc_q;
	assign halted_out = halt_q;

	always_comb begin
		unique case (ph_q)
			PH_FETCH: ph_d = PH_READ;
			PH_READ: ph_d = PH_EXEC;
			PH_EXEC: ph_d = PH_DONE;
			PH_DONE: ph_d = PH_FETCH;
		endcase
	end

	mie_alu u_alu (
		.acc_in(acc_q),
		.opnd_in(alu_b_w),
		.carry_in(fl_q.c),
		.nib_in(fl_q.ac),
		.op_in(alu_op_w),
		.res_out(alu_w)
	);

	always_comb begin
		res_w = mem_w;
		wr_mem_w = 1'b0;
		wr_acc_w = 1'b0;
		skip_w = 1'b0;
		jmp_w = 1'b0;
		call_w = 1'b0;
		ret_w = 1'b0;
		interrupt_return_w = 1'b0;
		tbl_w = 1'b0;
		tbl_last_w = 1'b0;
		kick_w = 1'b0;
		halt_w = 1'b0;
		upd_ar_w = 1'b0;
		upd_z_w = 1'b0;
		upd_c_w = 1'b0;
		case (opc_w)
			OP_MOVAM: wr_acc_w = 1'b1;
			OP_MOVMA: begin
				res_w = acc_q;
				wr_mem_w = 1'b1;
			end
			OP_MOVAX: begin
				res_w = m_w;
				wr_acc_w = 1'b1;
			end
			OP_CLRB: begin
				res_w = mem_w & ~mask_w;
				wr_mem_w = 1'b1;
			end
			OP_SETB: begin
				res_w = mem_w | mask_w;
				wr_mem_w = 1'b1;
			end
			OP_JMP: jmp_w = 1'b1;
			OP_SZ: skip_w = (mem_w == 8'h00);
			OP_SZA: begin
				wr_acc_w = 1'b1;
				skip_w = (mem_w == 8'h00);
			end
			OP_SZB: skip_w = ~|(mem_w & mask_w);
			OP_SNZB: skip_w = |(mem_w & mask_w);
			OP_SIZ, OP_SIZA: begin
				res_w = mem_w + 8'h01;
				wr_mem_w = (opc_w == OP_SIZ);
				wr_acc_w = (opc_w == OP_SIZA);
				skip_w = (res_w == 8'h00);
			end
			OP_SDZ, OP_SDZA: begin
				res_w = mem_w - 8'h01;
				wr_mem_w = (opc_w == OP_SDZ);
				wr_acc_w = (opc_w == OP_SDZA);
				skip_w = (res_w == 8'h00);
			end
			OP_CALL: call_w = 1'b1;
			OP_RET: ret_w = 1'b1;
			OP_RETA: begin
				ret_w = 1'b1;
				res_w = m_w;
				wr_acc_w = 1'b1;
			end
			OP_INTERRUPT_RETURN: begin
				ret_w = 1'b1;
				interrupt_return_w = 1'b1;
			end
			OP_TABLE_READ_PAGE: tbl_w = 1'b1;
			OP_TABLE_READ_FINAL_PAGE: begin
				tbl_w = 1'b1;
				tbl_last_w = 1'b1;
			end
			OP_CLR: begin
				res_w = 8'h00;
				wr_mem_w = 1'b1;
			end
			OP_SET: begin
				res_w = 8'hFF;
				wr_mem_w = 1'b1;
			end
			OP_KICK: kick_w = 1'b1;
			OP_HALT: halt_w = 1'b1;
			OP_ALUA, OP_ALUM, OP_ALUX: begin
				res_w = alu_w.res;
				wr_acc_w = (opc_w != OP_ALUM);
				wr_mem_w = (opc_w == OP_ALUM);
				upd_ar_w = (alu_op_w == ALU_ADD) | (alu_op_w == ALU_ADC);
				upd_z_w = (alu_op_w == ALU_AND) | (alu_op_w == ALU_CPL);
				upd_c_w = (alu_op_w == ALU_DAA);
			end
			default: res_w = mem_w;
		endcase
	end

	assign pcl_w = wr_mem_w & (m_w == PCL_ADDR);
	assign ram_we_w = (exec_w & wr_mem_w) | (dum_w & tbl_pend_q);
	assign ram_wd_w = tbl_pend_q ? tword_q[7:0] : res_w;
	assign wdt_exp_w = cyc_end_w & (&wdt_q);

	mie_dmem #(.DEPTH(DMEM_DEPTH), .AW(8)) u_dmem (
		.sys_clk_in(sys_clk_in),
		.we_in(ram_we_w),
		.addr_in(m_w),
		.wdata_in(ram_wd_w),
		.rdata_out(ram_rd_w)
	);

	// ==========================================
	// Sequencing
	// ==========================================
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			ph_q <= PH_FETCH;
			pc_q <= '0;
			ir_q <= '0;
			tword_q <= '0;
			dummy_q <= 1'b0;
			tbl_pend_q <= 1'b0;
			tbl_addr_q <= '0;
			sp_q <= '0;
		end else if (run_w) begin
			ph_q <= ph_d;
			if (ph_q == PH_FETCH && !dummy_q) begin
				ir_q <= prog_data_in;
			end
			if (ph_q == PH_FETCH && tbl_pend_q) begin
				tword_q <= prog_data_in;
			end
			if (dum_w) begin
				dummy_q <= 1'b0;
				tbl_pend_q <= 1'b0;
			end
			if (exec_w) begin
				dummy_q <= skip_w | jmp_w | call_w | ret_w | pcl_w | tbl_w;
				tbl_pend_q <= tbl_w;
				tbl_addr_q <= {tbl_last_w ? LAST_PAGE : tbhp_q[2:0], tblp_q};
				if (jmp_w || call_w) begin
					pc_q <= tgt_w;
				end else if (ret_w) begin
					pc_q <= pop_w;
				end else if (pcl_w) begin
					pc_q <= {pc_q[PC_W-1:8], res_w};
				end else if (skip_w) begin
					pc_q <= pc_q + PC_W'(2);
				end else begin
					pc_q <= pc_q + PC_W'(1);
				end
				if (call_w) begin
					sp_q <= sp_q + SPW'(1);
				end else if (ret_w) begin
					sp_q <= sp_q - SPW'(1);
				end
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (exec_w && call_w) begin
			stack_q[sp_q] <= pc_q + PC_W'(1);
		end
	end

	// ==========================================
	// Accumulator, flags, specials, watchdog
	// ==========================================
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			acc_q <= 8'h00;
			fl_q <= '0;
			tblp_q <= 8'h00;
			tbhp_q <= 8'h00;
			table_high_latch_q <= 8'h00;
			halt_q <= 1'b0;
			wdt_q <= '0;
		end else begin
			if (exec_w && wr_acc_w) begin
				acc_q <= res_w;
			end
			if (exec_w && upd_ar_w) begin
				fl_q.ov <= alu_w.ov;
				fl_q.ac <= alu_w.ac;
				fl_q.c <= alu_w.c;
			end
			if (exec_w && (upd_ar_w || upd_z_w)) begin
				fl_q.z <= alu_w.z;
			end
			if (exec_w && upd_c_w) begin
				fl_q.c <= alu_w.c;
			end
			if (exec_w && wr_mem_w && m_w == TBLP_ADDR) begin
				tblp_q <= res_w;
			end
			if (exec_w && wr_mem_w && m_w == TBHP_ADDR) begin
				tbhp_q <= res_w;
			end
			if (dum_w && tbl_pend_q) begin
				table_high_latch_q <= tword_q[15:8];
			end
			if (exec_w && interrupt_return_w) begin
				fl_q.global_irq_enable <= 1'b1;
			end else if (bus_wr_w && avs_writedata_in[CTRL_IRQ_OFF]) begin
				fl_q.global_irq_enable <= 1'b0;
			end
			if (exec_w && (kick_w || halt_w)) begin
				wdt_q <= '0;
				fl_q.sleep_entry_flag <= halt_w;
				fl_q.to <= 1'b0;
			end else if (cyc_end_w) begin
				wdt_q <= wdt_q + WDT_BITS'(1);
			end
			if (wdt_exp_w) begin
				fl_q.to <= 1'b1;
			end
			if (exec_w && halt_w) begin
				halt_q <= 1'b1;
			end else if (bus_wr_w && avs_writedata_in[CTRL_WAKE]) begin
				halt_q <= 1'b0;
			end
		end
	end

	// ==========================================
	// Avalon-MM slave
	// ==========================================
	assign bus_w = avs_read_in | avs_write_in;
	assign avs_waitrequest_out = bus_w & ~ack_q;
	assign bus_wr_w = avs_write_in & ack_q & (avs_address_in == REG_CTRL);

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			ack_q <= 1'b0;
			run_en_q <= CTRL_RUN_RST;
			avs_readdata_out <= 32'h0000_0000;
		end else begin
			ack_q <= bus_w & ~ack_q;
			if (bus_wr_w) begin
				run_en_q <= avs_writedata_in[CTRL_RUN];
			end
			if (avs_read_in && !ack_q) begin
				unique case (avs_address_in)
					REG_CTRL: avs_readdata_out <= {31'h0, run_en_q};
					REG_STATUS: avs_readdata_out <= {24'h0, halt_q, fl_q};
					REG_PC: avs_readdata_out <= {21'h0, pc_q};
					REG_ACC: avs_readdata_out <= {24'h0, acc_q};
					REG_WDT: avs_readdata_out <= 32'(wdt_q);
					default: avs_readdata_out <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ==========================================
	// Checks
	// ==========================================
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);

	skip_dummy_a: assert property (exec_w && skip_w |=> dummy_q)
		else $error("taken skip without dummy cycle");
	noskip_next_a: assert property (exec_w && opc_w == OP_SZ && !skip_w
		|=> !dummy_q && pc_q == $past(pc_q) + PC_W'(1))
		else $error("untaken skip stalled");
	pcl_two_a: assert property (exec_w && pcl_w |=> dummy_q)
		else $error("pc low write in one cycle");
	jump_flags_a: assert property (exec_w && (jmp_w || ret_w)
		|=> dummy_q && $stable(fl_q.c) && $stable(fl_q.z))
		else $error("branch changed flags or skipped dummy");
	call_push_a: assert property (exec_w && call_w
		|=> pc_q == $past(tgt_w)
		&& stack_q[sp_q - SPW'(1)] == $past(pc_q) + PC_W'(1))
		else $error("call push or target wrong");
	kick_clear_a: assert property (exec_w && kick_w && !wdt_exp_w
		|=> !fl_q.to && !fl_q.sleep_entry_flag && wdt_q == '0)
		else $error("watchdog kick incomplete");
	halt_flags_a: assert property (exec_w && halt_w && !wdt_exp_w
		|=> fl_q.sleep_entry_flag && !fl_q.to && halt_q && $stable(fl_q.z))
		else $error("power down flags wrong");
	move_flags_a: assert property (exec_w && opc_w inside {OP_MOVAM,
		OP_MOVMA, OP_MOVAX} |=> $stable(fl_q))
		else $error("move changed flags");
	and_only_z_a: assert property (exec_w && opc_w != OP_ALUM
		&& alu_op_w == ALU_AND && opc_w inside {OP_ALUA, OP_ALUX}
		|=> $stable(fl_q.c) && fl_q.z == (acc_q == 8'h00))
		else $error("and touched other flags");
	daa_carry_a: assert property (exec_w && opc_w == OP_ALUM
		&& alu_op_w == ALU_DAA
		|=> $stable(fl_q.z) && $stable(fl_q.ov) && $stable(acc_q))
		else $error("decimal adjust touched other state");

	jump_c: cover property (exec_w && jmp_w ##4 exec_w);
	skip_c: cover property (exec_w && skip_w);
	table_c: cover property (dum_w && tbl_pend_q);
	halt_c: cover property (exec_w && halt_w ##[1:20] !halt_q);
endmodule // mie_core

/* testbench/mie_prog_rom.sv */
// Program memory model answering the core's fetch address
`timescale 1ns/1ns
module mie_prog_rom (
	input wire logic sys_clk_in,
	input wire logic clear_in,
	input wire logic load_en_in,
	input wire logic [mie_pkg::PC_W-1:0] load_addr_in,
	input wire logic [mie_pkg::IW-1:0] load_data_in,
	input wire logic [mie_pkg::PC_W-1:0] addr_in,
	output logic [mie_pkg::IW-1:0] data_out
);
	import mie_pkg::*;
	logic [IW-1:0] mem_q [0:(1<<PC_W)-1];
	// ==========================================
	// Loading from the bench, zero latency read
	always_ff @(posedge sys_clk_in) begin
		if (clear_in) begin
			for (int i = 0; i < (1 << PC_W); i++) begin
				mem_q[i] <= 16'h0000;
			end
		end else if (load_en_in) begin
			mem_q[load_addr_in] <= load_data_in;
		end
	end
	assign data_out = mem_q[addr_in];
endmodule // mie_prog_rom

/* testbench/test_mie_core.sv */
// Self-checking bench for the instruction execution core
`timescale 1ns/1ns
module test_mie_core;
	import mie_pkg::*;
	localparam int WDT_SIM = 4;
	logic sys_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [4:0] avs_address_in = 5'h00;
	logic avs_read_in = 1'b0;
	logic avs_write_in = 1'b0;
	logic [31:0] avs_writedata_in = 32'h00000000;
	logic [31:0] avs_readdata_out;
	logic avs_waitrequest_out;
	logic [PC_W-1:0] prog_addr_out;
	logic [IW-1:0] prog_data_in;
	logic halted_out;
	logic rom_clear = 1'b0;
	logic rom_en = 1'b0;
	logic [PC_W-1:0] rom_addr = 11'h000;
	logic [IW-1:0] rom_data = 16'h0000;
	int num_errors = 0;
	int n_checks = 0;
	int base_clks = 0;
	logic [PC_W-1:0] addrs[$];
	logic [IW-1:0] words[$];

	always #10 sys_clk_in = ~sys_clk_in;

	mie_core #(.WDT_BITS(WDT_SIM)) i_mie_core (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.avs_address_in(avs_address_in),
		.avs_read_in(avs_read_in),
		.avs_write_in(avs_write_in),
		.avs_writedata_in(avs_writedata_in),
		.avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out),
		.prog_addr_out(prog_addr_out),
		.prog_data_in(prog_data_in),
		.halted_out(halted_out)
	);

	mie_prog_rom i_mie_prog_rom (
		.sys_clk_in(sys_clk_in),
		.clear_in(rom_clear),
		.load_en_in(rom_en),
		.load_addr_in(rom_addr),
		.load_data_in(rom_data),
		.addr_in(prog_addr_out),
		.data_out(prog_data_in)
	);

	// ==========================================
	// Shared helpers
	task automatic conclude();
		if (num_errors == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	function automatic logic [15:0] wd(input logic [4:0] op,
		input logic [2:0] sub, input logic [7:0] m);
		return {op, sub, m};
	endfunction

	task automatic put(input int a, input logic [15:0] w);
		addrs.push_back(a[PC_W-1:0]);
		words.push_back(w);
	endtask

	// ==========================================
	// Avalon master, waitrequest sampled before each edge
	task automatic bus_write(input logic [4:0] a, input logic [31:0] d);
		logic w;
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_write_in <= 1'b1;
		do begin
			@(negedge sys_clk_in);
			w = avs_waitrequest_out;
			@(posedge sys_clk_in);
		end while (w !== 1'b0);
		avs_write_in <= 1'b0;
		@(posedge sys_clk_in);
	endtask

	task automatic bus_read(input logic [4:0] a, output logic [31:0] d);
		logic w;
		avs_address_in <= a;
		avs_read_in <= 1'b1;
		do begin
			@(negedge sys_clk_in);
			w = avs_waitrequest_out;
			@(posedge sys_clk_in);
		end while (w !== 1'b0);
		d = avs_readdata_out;
		avs_read_in <= 1'b0;
		@(posedge sys_clk_in);
	endtask

	// Reset, load, run to power down, judge acc, flags and time
	task automatic run_prog(input logic [7:0] acc, input logic [3:0] fl,
		input int extra);
		logic [31:0] d;
		int n;
		rst_n_in <= 1'b0;
		rom_clear <= 1'b1;
		@(posedge sys_clk_in);
		rom_clear <= 1'b0;
		foreach (words[i]) begin
			rom_en <= 1'b1;
			rom_addr <= addrs[i];
			rom_data <= words[i];
			@(posedge sys_clk_in);
		end
		rom_en <= 1'b0;
		rst_n_in <= 1'b1;
		words.delete();
		addrs.delete();
		@(posedge sys_clk_in);
		bus_write(REG_CTRL, 32'h00000001);
		n = 0;
		while (halted_out !== 1'b1 && n < 3000) begin
			@(negedge sys_clk_in);
			n++;
		end
		@(posedge sys_clk_in);
		if (extra < 0) begin
			base_clks = n;
		end else begin
			check("clocks", 32'(n - base_clks), 32'(extra));
		end
		bus_read(REG_ACC, d);
		check("acc", d, {24'h000000, acc});
		bus_read(REG_STATUS, d);
		check("status", d & 32'h000000BF, {24'h000000, 4'h9, fl});
	endtask

	// ==========================================
	// Scenarios
	task automatic t_base();
		put(0, wd(OP_HALT, 3'h0, 8'h00));
		run_prog(8'h00, 4'h0, -1);
	endtask

	task automatic t_arith();
		put(0, wd(OP_MOVAX, 3'h0, 8'h55));
		put(1, wd(OP_MOVMA, 3'h0, 8'h20));
		put(2, wd(OP_MOVAX, 3'h0, 8'hFF));
		put(3, wd(OP_ALUX, ALU_ADD, 8'h01));
		put(4, wd(OP_MOVAX, 3'h0, 8'hAA));
		put(5, wd(OP_ALUA, ALU_ADC, 8'h20));
		put(6, wd(OP_HALT, 3'h0, 8'h00));
		run_prog(8'h00, 4'b0111, 24);
	endtask

	task automatic t_logic();
		put(0, wd(OP_MOVAX, 3'h0, 8'h7F));
		put(1, wd(OP_ALUX, ALU_ADD, 8'h01));
		put(2, wd(OP_MOVAX, 3'h0, 8'h3C));
		put(3, wd(OP_MOVMA, 3'h0, 8'h21));
		put(4, wd(OP_MOVAX, 3'h0, 8'h0F));
		put(5, wd(OP_ALUM, ALU_AND, 8'h21));
		put(6, wd(OP_SETB, 3'h6, 8'h21));
		put(7, wd(OP_CLRB, 3'h2, 8'h21));
		put(8, wd(OP_ALUM, ALU_CPL, 8'h21));
		put(9, wd(OP_ALUA, ALU_SWAP, 8'h21));
		put(10, wd(OP_HALT, 3'h0, 8'h00));
		run_prog(8'h7B, 4'b1010, 40);
	endtask

	task automatic t_flow();
		put(0, wd(OP_CLR, 3'h0, 8'h23));
		put(1, wd(5'h07, 3'h0, 8'h23));
		put(2, wd(OP_MOVAX, 3'h0, 8'h11));
		put(3, wd(OP_SET, 3'h0, 8'h23));
		put(4, wd(5'h0B, 3'h0, 8'h23));
		put(5, wd(OP_MOVAX, 3'h0, 8'h22));
		put(6, wd(OP_SNZB, 3'h0, 8'h23));
		put(7, wd(OP_MOVAX, 3'h0, 8'h33));
		put(8, wd(OP_CALL, 3'h0, 8'h0C));
		put(9, wd(OP_ALUX, ALU_ADD, 8'h10));
		put(10, wd(OP_HALT, 3'h0, 8'h00));
		put(12, wd(OP_ALUX, ALU_ADD, 8'h01));
		put(13, wd(OP_RET, 3'h0, 8'h00));
		run_prog(8'h44, 4'b0000, 56);
	endtask

	task automatic t_misc();
		put(0, wd(5'h06, 3'h0, 8'h03));
		put(3, wd(OP_MOVAX, 3'h0, 8'h07));
		put(4, wd(OP_MOVMA, 3'h0, 8'h06));
		put(5, wd(OP_MOVAX, 3'h0, 8'hEE));
		put(7, wd(OP_KICK, 3'h0, 8'h00));
		put(8, wd(OP_MOVAX, 3'h0, 8'h20));
		put(9, wd(OP_MOVMA, 3'h0, 8'h07));
		put(10, wd(OP_MOVAX, 3'h0, 8'h00));
		put(11, wd(OP_MOVMA, 3'h0, 8'h09));
		put(12, wd(5'h13, 3'h0, 8'h25));
		put(13, wd(OP_MOVAX, 3'h0, 8'hAA));
		put(14, wd(OP_ALUM, 3'h4, 8'h24));
		put(15, wd(OP_ALUA, ALU_AND, 8'h24));
		put(16, wd(OP_MOVAM, 3'h0, 8'h08));
		put(17, wd(OP_HALT, 3'h0, 8'h00));
		put(32, 16'hAB12);
		run_prog(8'hAB, 4'b0101, 64);
	endtask

	task automatic t_bus();
		logic [31:0] d;
		bus_read(REG_CTRL, d);
		check("ctrl run", d, 32'h00000001);
		bus_write(REG_CTRL, 32'h00000000);
		bus_read(REG_CTRL, d);
		check("ctrl stop", d, 32'h00000000);
		bus_write(5'h14, 32'h000000FF);
		bus_read(5'h14, d);
		check("unmapped", d, 32'h00000000);
	endtask

	// ==========================================
	// Sequence and watchdog
	initial begin
		repeat (40000) @(posedge sys_clk_in);
		num_errors++;
		conclude();
	end

	initial begin
		repeat (16) @(posedge sys_clk_in);
		t_base();
		t_arith();
		t_logic();
		t_flow();
		t_misc();
		t_bus();
		conclude();
	end
endmodule // test_mie_core
